//--- rtl/sfrdp_pkg.sv
// constants and types of the special-function register space with dual data pointers
// ==========================================================================
package sfrdp_pkg;

  // ==========================================================================
  // register addresses
  localparam logic [7:0] SFRDP_SFR_BASE   = 8'h80;
  localparam logic [7:0] SFRDP_ADDR_PORT0 = 8'h80;
  localparam logic [7:0] SFRDP_ADDR_SP    = 8'h81;
  localparam logic [7:0] SFRDP_ADDR_DPL0  = 8'h82;
  localparam logic [7:0] SFRDP_ADDR_DPH0  = 8'h83;
  localparam logic [7:0] SFRDP_ADDR_DPL1  = 8'h84;
  localparam logic [7:0] SFRDP_ADDR_DPH1  = 8'h85;
  localparam logic [7:0] SFRDP_ADDR_PCTL  = 8'h86;
  localparam logic [7:0] SFRDP_ADDR_TL0   = 8'h8A;
  localparam logic [7:0] SFRDP_ADDR_TL1   = 8'h8B;
  localparam logic [7:0] SFRDP_ADDR_TH0   = 8'h8C;
  localparam logic [7:0] SFRDP_ADDR_TH1   = 8'h8D;
  localparam logic [7:0] SFRDP_ADDR_PORT1 = 8'h90;
  localparam logic [7:0] SFRDP_ADDR_PORT2 = 8'hA0;
  localparam logic [7:0] SFRDP_ADDR_PORT3 = 8'hB0;
  localparam logic [7:0] SFRDP_ADDR_TL2   = 8'hCC;
  localparam logic [7:0] SFRDP_ADDR_TH2   = 8'hCD;

  // ==========================================================================
  // pointer control fields
  localparam int SFRDP_BIT_SEL  = 0;
  localparam int SFRDP_BIT_DIR  = 4;
  localparam int SFRDP_BIT_TGL  = 5;
  localparam int SFRDP_BIT_ID0  = 6;
  localparam int SFRDP_BIT_ID1  = 7;
  localparam logic [7:0] SFRDP_PCTL_MASK = 8'hF1;
  localparam int SFRDP_BITADDR_W = 3;

  // ==========================================================================
  // reset values and sizes
  localparam logic [7:0] SFRDP_RST_PORT = 8'hFF;
  localparam logic [7:0] SFRDP_RST_SP   = 8'h07;
  localparam logic [7:0] SFRDP_RST_ZERO = 8'h00;
  localparam int SFRDP_XRAM_BYTES = 1024;
  localparam int SFRDP_MAX_STRETCH = 10;
  localparam logic [15:0] SFRDP_XRAM_END  = 16'h03FF;
  localparam logic [15:0] SFRDP_PERIPH_LO = 16'hFF00;

  typedef enum logic [1:0] {
    SFRDP_TGT_XRAM,
    SFRDP_TGT_EXTMEM,
    SFRDP_TGT_PERIPH
  } sfrdp_target_t;

endpackage : sfrdp_pkg

//--- rtl/sfrdp_xram.sv
// one kilobyte on-chip extended data RAM
module sfrdp_xram
  import sfrdp_pkg::*;
#(
  parameter int DEPTH = SFRDP_XRAM_BYTES,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic          clk,
  input  wire logic          wrEn,
  input  wire logic [AW-1:0] addr,
  input  wire logic [7:0]    wrData,
  output logic      [7:0]    rdData
);
  logic [7:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (wrEn) begin
      mem[addr] <= wrData;
    end
    rdData <= mem[addr];
  end
endmodule : sfrdp_xram

//--- rtl/sfrdp_stretch.sv
// stretch counter for external moves
module sfrdp_stretch
  import sfrdp_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       start,
  input  wire logic [3:0] stretchCycles,
  output logic            busy,
  output logic            done
);
  logic [3:0] cnt_q;
  logic [3:0] limit;

  assign limit = (stretchCycles > 4'(SFRDP_MAX_STRETCH)) ? 4'(SFRDP_MAX_STRETCH)
                                                           : stretchCycles;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_q <= 4'h0;
      busy  <= 1'b0;
      done  <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        if (limit == 4'h0) begin
          done <= 1'b1;
        end else begin
          busy  <= 1'b1;
          cnt_q <= limit;
        end
      end else if (busy) begin
        cnt_q <= cnt_q - 4'h1;
        if (cnt_q == 4'h1) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end

  property p_stretch_len;
    @(posedge clk) disable iff (sys_rst)
    (start && !busy && limit == 4'h2) |=> busy ##1 busy ##1 done;
  endproperty
  a_stretch_len: assert property (p_stretch_len)
    else $error("stretch length wrong");
endmodule : sfrdp_stretch

//--- rtl/sfrdp_sfr_space.sv
// special-function register space and dual data-pointer unit
module sfrdp_sfr_space
  import sfrdp_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // direct-address register access
  input  wire logic        dirValid,
  input  wire logic        dirIndirect,
  input  wire logic        dirWrite,
  input  wire logic        dirBitOp,
  input  wire logic [7:0]  dirAddr,
  input  wire logic [2:0]  dirBitSel,
  input  wire logic [7:0]  dirWrData,
  output logic      [7:0]  dirRdData,
  output logic             dirHit,
  output logic             dirBitError,
  // external-move access
  input  wire logic        xmvValid,
  input  wire logic        xmvWrite,
  input  wire logic [7:0]  xmvWrData,
  input  wire logic        instrDone,
  input  wire logic        instrUsedPtr,
  input  wire logic [3:0]  stretchCycles,
  input  wire logic        xramEnable,
  output logic             xmvReady,
  output logic      [7:0]  xmvRdData,
  output logic      [15:0] extAddr,
  output logic             extMemSel,
  output logic             periphSel,
  output logic             extWrite,
  input  wire logic [7:0]  extRdData,
  // latch and status outputs
  output logic      [31:0] portLatches,
  output logic      [7:0]  stackPointer,
  output logic      [47:0] timerValues,
  output logic             activePtr
);
  // ==========================================================================
  // storage
  logic [7:0]  port_q [4];
  logic [7:0]  sp_q;
  logic [15:0] data_pointer_zero_q [2];
  logic [7:0]  pctl_q;
  logic [7:0]  tmr_q [6];
  logic [7:0]  curByte;
  logic [7:0]  newByte;
  logic        sfrAcc;
  logic        bitOk;
  logic        doWrite;
  logic        sel;
  logic [15:0] ptr;
  sfrdp_target_t tgt;
  logic        stBusy;
  logic        stDone;
  logic        xmvPend_q;
  logic [7:0]  xramRd;
  logic        xramWr;

  assign sfrAcc  = dirValid && !dirIndirect && dirAddr >= SFRDP_SFR_BASE;
  assign bitOk   = dirAddr[SFRDP_BITADDR_W-1:0] == 3'h0;
  assign doWrite = sfrAcc && dirWrite && (!dirBitOp || bitOk);
  assign dirBitError = sfrAcc && dirBitOp && !bitOk;

  // ==========================================================================
  // read mux
  always_comb begin
    curByte = SFRDP_RST_ZERO;
    dirHit  = 1'b1;
    unique case (dirAddr)
      SFRDP_ADDR_PORT0: curByte = port_q[0];
      SFRDP_ADDR_PORT1: curByte = port_q[1];
      SFRDP_ADDR_PORT2: curByte = port_q[2];
      SFRDP_ADDR_PORT3: curByte = port_q[3];
      SFRDP_ADDR_SP:    curByte = sp_q;
      SFRDP_ADDR_DPL0:  curByte = data_pointer_zero_q[0][7:0];
      SFRDP_ADDR_DPH0:  curByte = data_pointer_zero_q[0][15:8];
      SFRDP_ADDR_DPL1:  curByte = data_pointer_zero_q[1][7:0];
      SFRDP_ADDR_DPH1:  curByte = data_pointer_zero_q[1][15:8];
      SFRDP_ADDR_PCTL:  curByte = pctl_q;
      SFRDP_ADDR_TL0:   curByte = tmr_q[0];
      SFRDP_ADDR_TH0:   curByte = tmr_q[1];
      SFRDP_ADDR_TL1:   curByte = tmr_q[2];
      SFRDP_ADDR_TH1:   curByte = tmr_q[3];
      SFRDP_ADDR_TL2:   curByte = tmr_q[4];
      SFRDP_ADDR_TH2:   curByte = tmr_q[5];
      default:          dirHit  = 1'b0;
    endcase
    if (!sfrAcc) begin
      dirHit = 1'b0;
    end
  end

  // single bit modify or whole byte
  always_comb begin
    newByte = dirWrData;
    if (dirBitOp) begin
      newByte = curByte;
      newByte[dirBitSel] = dirWrData[0];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dirRdData <= SFRDP_RST_ZERO;
    end else if (sfrAcc && !dirWrite) begin
      dirRdData <= (dirBitOp && bitOk) ? {7'h00, curByte[dirBitSel]} : curByte;
    end
  end

  // ==========================================================================
  // ports, stack pointer, timers
  for (genvar i = 0; i < 4; i++) begin : g_port
    logic [7:0] portAddr;
    assign portAddr = (i == 0) ? SFRDP_ADDR_PORT0 : (i == 1) ? SFRDP_ADDR_PORT1 :
                      (i == 2) ? SFRDP_ADDR_PORT2 : SFRDP_ADDR_PORT3;
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        port_q[i] <= SFRDP_RST_PORT;
      end else if (doWrite && dirAddr == portAddr) begin
        port_q[i] <= newByte;
      end
    end
    assign portLatches[i*8 +: 8] = port_q[i];
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sp_q <= SFRDP_RST_SP;
    end else if (doWrite && dirAddr == SFRDP_ADDR_SP) begin
      sp_q <= newByte;
    end
  end
  assign stackPointer = sp_q;

  for (genvar t = 0; t < 6; t++) begin : g_tmr
    logic [7:0] tAddr;
    assign tAddr = (t == 0) ? SFRDP_ADDR_TL0 : (t == 1) ? SFRDP_ADDR_TH0 :
                   (t == 2) ? SFRDP_ADDR_TL1 : (t == 3) ? SFRDP_ADDR_TH1 :
                   (t == 4) ? SFRDP_ADDR_TL2 : SFRDP_ADDR_TH2;
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        tmr_q[t] <= SFRDP_RST_ZERO;
      end else if (doWrite && dirAddr == tAddr) begin
        tmr_q[t] <= newByte;
      end
    end
    assign timerValues[t*8 +: 8] = tmr_q[t];
  end

  // ==========================================================================
  // pointer control and data pointers
  wire ptrUse = instrDone && instrUsedPtr;
  assign sel       = pctl_q[SFRDP_BIT_SEL];
  assign activePtr = sel;
  assign ptr       = data_pointer_zero_q[sel];

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pctl_q <= SFRDP_RST_ZERO;
    end else if (doWrite && dirAddr == SFRDP_ADDR_PCTL) begin
      pctl_q <= newByte & SFRDP_PCTL_MASK;
    end else if (ptrUse && pctl_q[SFRDP_BIT_TGL]) begin
      pctl_q[SFRDP_BIT_SEL] <= !sel;
    end
  end

  for (genvar p = 0; p < 2; p++) begin : g_data_pointer_zero
    logic [7:0] loAddr;
    logic [7:0] hiAddr;
    logic       stepEn;
    assign loAddr = p ? SFRDP_ADDR_DPL1 : SFRDP_ADDR_DPL0;
    assign hiAddr = p ? SFRDP_ADDR_DPH1 : SFRDP_ADDR_DPH0;
    assign stepEn = p ? pctl_q[SFRDP_BIT_ID1] : pctl_q[SFRDP_BIT_ID0];
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        data_pointer_zero_q[p] <= 16'h0000;
      end else if (doWrite && dirAddr == loAddr) begin
        data_pointer_zero_q[p][7:0] <= newByte;
      end else if (doWrite && dirAddr == hiAddr) begin
        data_pointer_zero_q[p][15:8] <= newByte;
      end else if (ptrUse && stepEn && sel == 1'(p)) begin
        data_pointer_zero_q[p] <= pctl_q[SFRDP_BIT_DIR] ? data_pointer_zero_q[p] - 16'h0001
                                           : data_pointer_zero_q[p] + 16'h0001;
      end
    end
  end

  // ==========================================================================
  // external-move routing
  always_comb begin
    if (xramEnable && ptr <= SFRDP_XRAM_END) begin
      tgt = SFRDP_TGT_XRAM;
    end else if (ptr >= SFRDP_PERIPH_LO) begin
      tgt = SFRDP_TGT_PERIPH;
    end else begin
      tgt = SFRDP_TGT_EXTMEM;
    end
  end

  assign extAddr   = ptr;
  assign extMemSel = xmvValid && tgt == SFRDP_TGT_EXTMEM;
  assign periphSel = xmvValid && tgt == SFRDP_TGT_PERIPH;
  assign extWrite  = xmvValid && xmvWrite && tgt != SFRDP_TGT_XRAM;
  assign xramWr    = xmvValid && xmvWrite && tgt == SFRDP_TGT_XRAM && stDone;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      xmvPend_q <= 1'b0;
    end else begin
      xmvPend_q <= xmvValid && !stDone;
    end
  end

  sfrdp_stretch u_stretch (
    .clk           (clk),
    .sys_rst       (sys_rst),
    .start         (xmvValid && !xmvPend_q),
    .stretchCycles (stretchCycles),
    .busy          (stBusy),
    .done          (stDone)
  );

  sfrdp_xram u_xram (
    .clk    (clk),
    .wrEn   (xramWr),
    .addr   (ptr[9:0]),
    .wrData (xmvWrData),
    .rdData (xramRd)
  );

  assign xmvReady = stDone;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      xmvRdData <= SFRDP_RST_ZERO;
    end else if (stDone && !xmvWrite) begin
      xmvRdData <= (tgt == SFRDP_TGT_XRAM) ? xramRd : extRdData;
    end
  end

  // ==========================================================================
  // checks
  property p_indirect_ignored;
    @(posedge clk) disable iff (sys_rst)
    (dirValid && dirIndirect) |-> !dirHit && !dirBitError;
  endproperty
  a_indirect_ignored: assert property (p_indirect_ignored)
    else $error("indirect access reached register space");

  property p_bit_align;
    @(posedge clk) disable iff (sys_rst)
    (sfrAcc && dirBitOp && dirAddr[2:0] != 3'h0) |-> dirBitError;
  endproperty
  a_bit_align: assert property (p_bit_align)
    else $error("bit access allowed at unaligned address");

  property p_addr_sel;
    @(posedge clk) disable iff (sys_rst)
    extAddr == (pctl_q[0] ? data_pointer_zero_q[1] : data_pointer_zero_q[0]);
  endproperty
  a_addr_sel: assert property (p_addr_sel)
    else $error("external address not from selected pointer");

  property p_toggle;
    @(posedge clk) disable iff (sys_rst)
    (ptrUse && pctl_q[SFRDP_BIT_TGL] && !doWrite) |=> activePtr != $past(activePtr);
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("pointer selection did not toggle");

  property p_incr;
    @(posedge clk) disable iff (sys_rst)
    (ptrUse && !doWrite && !sel && pctl_q[SFRDP_BIT_ID0] && !pctl_q[SFRDP_BIT_DIR])
    |=> data_pointer_zero_q[0] == $past(data_pointer_zero_q[0]) + 16'h0001;
  endproperty
  a_incr: assert property (p_incr)
    else $error("pointer zero did not increment");

  property p_decr_one;
    @(posedge clk) disable iff (sys_rst)
    (ptrUse && !doWrite && sel && pctl_q[SFRDP_BIT_ID1] && pctl_q[SFRDP_BIT_DIR])
    |=> data_pointer_zero_q[1] == $past(data_pointer_zero_q[1]) - 16'h0001;
  endproperty
  a_decr_one: assert property (p_decr_one)
    else $error("pointer one did not decrement");

  property p_route;
    @(posedge clk) disable iff (sys_rst)
    (xmvValid && xramEnable && ptr <= SFRDP_XRAM_END) |-> !extMemSel && !periphSel;
  endproperty
  a_route: assert property (p_route)
    else $error("on-chip RAM access leaked off chip");

  property p_ready_pulse;
    @(posedge clk) disable iff (sys_rst)
    xmvReady |=> !xmvReady;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("move answer longer than one cycle");

  property p_busy_quiet;
    @(posedge clk) disable iff (sys_rst)
    stBusy |-> !xmvReady;
  endproperty
  a_busy_quiet: assert property (p_busy_quiet)
    else $error("move answered while still stretching");

  property p_port_hold;
    @(posedge clk) disable iff (sys_rst)
    (doWrite && !dirBitOp && dirAddr == SFRDP_ADDR_PORT2)
    |=> portLatches[23:16] == $past(dirWrData);
  endproperty
  a_port_hold: assert property (p_port_hold)
    else $error("port latch did not keep written value");

  property p_sp_load;
    @(posedge clk) disable iff (sys_rst)
    (doWrite && !dirBitOp && dirAddr == SFRDP_ADDR_SP) |=> stackPointer == $past(dirWrData);
  endproperty
  a_sp_load: assert property (p_sp_load)
    else $error("stack pointer load failed");
endmodule : sfrdp_sfr_space

//--- sim/sfrdp_ext_mem.sv
// far-side data memory and peripheral model
module sfrdp_ext_mem
  import sfrdp_pkg::*;
(
  input  wire logic        clk,
  input  wire logic [15:0] extAddr,
  input  wire logic        extMemSel,
  input  wire logic        periphSel,
  input  wire logic        extWrite,
  input  wire logic        xmvReady,
  input  wire logic [7:0]  xmvWrData,
  output logic      [7:0]  extRdData
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] mem [256];
  logic [7:0] lastQ;
  logic       selected;

  initial begin
    lastQ = 8'h00;
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'h00;
    end
  end

  assign selected = extMemSel | periphSel;

  // store at the sampling edge of the answer
  always @(posedge clk) begin
    if (selected && extWrite && xmvReady) begin
      mem[extAddr[7:0]] <= xmvWrData;
    end
    if (selected) begin
      lastQ <= extRdData;
    end
  end

  // released bus shows the inverse of the last value
  assign extRdData = selected ? mem[extAddr[7:0]] : ~lastQ;
endmodule : sfrdp_ext_mem

//--- sim/sfrdp_sfr_space_test.sv
// self-checking bench for register space and dual data pointers
module sfrdp_sfr_space_test
  import sfrdp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk, sys_rst, dirValid, dirIndirect, dirWrite, dirBitOp;
  logic        dirHit, dirBitError, xmvValid, xmvWrite, instrDone, instrUsedPtr;
  logic        xramEnable, xmvReady, extMemSel, periphSel, extWrite, activePtr;
  logic        lastHit, lastBitErr, seenMem, seenPer;
  logic [2:0]  dirBitSel;
  logic [3:0]  stretchCycles;
  logic [7:0]  dirAddr, dirWrData, dirRdData, xmvWrData, xmvRdData, extRdData;
  logic [7:0]  stackPointer, seenRd;
  logic [15:0] extAddr;
  logic [31:0] portLatches;
  logic [47:0] timerValues;
  int          nFail, checksDone, xmvCycles;

  sfrdp_sfr_space i_dut (
    .clk(clk), .sys_rst(sys_rst), .dirValid(dirValid), .dirIndirect(dirIndirect),
    .dirWrite(dirWrite), .dirBitOp(dirBitOp), .dirAddr(dirAddr), .dirBitSel(dirBitSel),
    .dirWrData(dirWrData), .dirRdData(dirRdData), .dirHit(dirHit),
    .dirBitError(dirBitError), .xmvValid(xmvValid), .xmvWrite(xmvWrite),
    .xmvWrData(xmvWrData), .instrDone(instrDone), .instrUsedPtr(instrUsedPtr),
    .stretchCycles(stretchCycles), .xramEnable(xramEnable), .xmvReady(xmvReady),
    .xmvRdData(xmvRdData), .extAddr(extAddr), .extMemSel(extMemSel),
    .periphSel(periphSel), .extWrite(extWrite), .extRdData(extRdData),
    .portLatches(portLatches), .stackPointer(stackPointer),
    .timerValues(timerValues), .activePtr(activePtr)
  );

  sfrdp_ext_mem i_mem (
    .clk(clk), .extAddr(extAddr), .extMemSel(extMemSel), .periphSel(periphSel),
    .extWrite(extWrite), .xmvReady(xmvReady), .xmvWrData(xmvWrData),
    .extRdData(extRdData)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ==================
  // bench tasks
  task automatic chk(input string what, input logic [47:0] seen, input logic [47:0] exp);
    checksDone++;
    if (seen !== exp) begin
      nFail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic dir_op(input logic wr, input logic bo, input logic ind,
                        input logic [7:0] a, input logic [2:0] b, input logic [7:0] d);
    @(negedge clk);
    dirValid    = 1'b1;
    dirWrite    = wr;
    dirBitOp    = bo;
    dirIndirect = ind;
    dirAddr     = a;
    dirBitSel   = b;
    dirWrData   = d;
    #1;
    lastHit     = dirHit;
    lastBitErr  = dirBitError;
    @(negedge clk);
    dirValid    = 1'b0;
    dirWrite    = 1'b0;
    dirBitOp    = 1'b0;
    dirIndirect = 1'b0;
  endtask : dir_op

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    dir_op(1'b1, 1'b0, 1'b0, a, 3'h0, d);
  endtask : wr

  task automatic rdchk(input string what, input logic [7:0] a, input logic [7:0] exp);
    dir_op(1'b0, 1'b0, 1'b0, a, 3'h0, 8'h00);
    chk(what, dirRdData, exp);
  endtask : rdchk

  task automatic set_ptr(input logic p, input logic [15:0] v);
    wr(p ? SFRDP_ADDR_DPL1 : SFRDP_ADDR_DPL0, v[7:0]);
    wr(p ? SFRDP_ADDR_DPH1 : SFRDP_ADDR_DPH0, v[15:8]);
  endtask : set_ptr

  task automatic xmv(input logic w, input logic [7:0] d);
    @(negedge clk);
    xmvValid  = 1'b1;
    xmvWrite  = w;
    xmvWrData = d;
    xmvCycles = 0;
    while (xmvReady !== 1'b1 && xmvCycles < 40) begin
      @(negedge clk);
      xmvCycles++;
    end
    chk("xmv answered", xmvCycles < 40, 1'b1);
    seenMem = extMemSel;
    seenPer = periphSel;
    @(negedge clk);
    seenRd   = xmvRdData;
    xmvValid = 1'b0;
    xmvWrite = 1'b0;
    @(negedge clk);
  endtask : xmv

  task automatic pulse(input logic used);
    @(negedge clk);
    instrDone    = 1'b1;
    instrUsedPtr = used;
    @(negedge clk);
    instrDone    = 1'b0;
    instrUsedPtr = 1'b0;
  endtask : pulse

  // ==================
  // scenarios
  task automatic t_reset();
    chk("ports", portLatches, {4{SFRDP_RST_PORT}});
    chk("sp", stackPointer, SFRDP_RST_SP);
    chk("timers", timerValues, 48'h0);
    chk("sel", activePtr, 1'b0);
  endtask : t_reset

  task automatic t_regs();
    logic [7:0] regs [11];
    regs = '{SFRDP_ADDR_PORT0, SFRDP_ADDR_SP, SFRDP_ADDR_TL0, SFRDP_ADDR_TL1,
             SFRDP_ADDR_TH0, SFRDP_ADDR_TH1, SFRDP_ADDR_PORT1, SFRDP_ADDR_PORT2,
             SFRDP_ADDR_PORT3, SFRDP_ADDR_TL2, SFRDP_ADDR_TH2};
    foreach (regs[i]) wr(regs[i], regs[i] ^ 8'h5A);
    foreach (regs[i]) rdchk("reg", regs[i], regs[i] ^ 8'h5A);
    chk("latches", portLatches, {SFRDP_ADDR_PORT3 ^ 8'h5A, SFRDP_ADDR_PORT2 ^ 8'h5A,
        SFRDP_ADDR_PORT1 ^ 8'h5A, SFRDP_ADDR_PORT0 ^ 8'h5A});
    chk("sp out", stackPointer, SFRDP_ADDR_SP ^ 8'h5A);
    chk("timers out", timerValues, {SFRDP_ADDR_TH2 ^ 8'h5A, SFRDP_ADDR_TL2 ^ 8'h5A,
        SFRDP_ADDR_TH1 ^ 8'h5A, SFRDP_ADDR_TL1 ^ 8'h5A,
        SFRDP_ADDR_TH0 ^ 8'h5A, SFRDP_ADDR_TL0 ^ 8'h5A});
  endtask : t_regs

  task automatic t_access();
    dir_op(1'b1, 1'b0, 1'b1, SFRDP_ADDR_PORT1, 3'h0, 8'h00);
    rdchk("indirect", SFRDP_ADDR_PORT1, SFRDP_ADDR_PORT1 ^ 8'h5A);
    wr(8'h7F, 8'h00);
    chk("low hit", lastHit, 1'b0);
    dir_op(1'b1, 1'b1, 1'b0, SFRDP_ADDR_PORT1, 3'h3, 8'h00);
    chk("hit", lastHit, 1'b1);
    chk("aligned", lastBitErr, 1'b0);
    rdchk("bit clr", SFRDP_ADDR_PORT1, (SFRDP_ADDR_PORT1 ^ 8'h5A) & 8'hF7);
    dir_op(1'b0, 1'b1, 1'b0, SFRDP_ADDR_PORT1, 3'h1, 8'h00);
    chk("bit rd", dirRdData, 8'h01);
    dir_op(1'b1, 1'b1, 1'b0, SFRDP_ADDR_SP, 3'h0, 8'h00);
    chk("unaligned", lastBitErr, 1'b1);
    rdchk("sp kept", SFRDP_ADDR_SP, SFRDP_ADDR_SP ^ 8'h5A);
    dir_op(1'b0, 1'b1, 1'b0, 8'h88, 3'h0, 8'h00);
    chk("nibble 8", lastBitErr, 1'b0);
  endtask : t_access

  task automatic t_ptr();
    set_ptr(1'b0, 16'h0010);
    set_ptr(1'b1, 16'hFF05);
    wr(SFRDP_ADDR_PCTL, 8'h00);
    chk("addr0", extAddr, 16'h0010);
    xmv(1'b1, 8'h5A);
    chk("xram sel", {seenMem, seenPer}, 2'b00);
    xmv(1'b0, 8'h00);
    chk("xram rd", seenRd, 8'h5A);
    wr(SFRDP_ADDR_PCTL, 8'h01);
    chk("addr1", extAddr, 16'hFF05);
    xmv(1'b1, 8'h3C);
    chk("periph", {seenMem, seenPer}, 2'b01);
    xmv(1'b0, 8'h00);
    chk("periph rd", seenRd, 8'h3C);
    wr(SFRDP_ADDR_PCTL, 8'h00);
    xramEnable = 1'b0;
    xmv(1'b1, 8'hA5);
    chk("ext wr sel", {seenMem, seenPer}, 2'b10);
    xmv(1'b0, 8'h00);
    chk("ext sel", {seenMem, seenPer}, 2'b10);
    chk("ext rd", seenRd, 8'hA5);
    xramEnable = 1'b1;
  endtask : t_ptr

  task automatic t_stretch();
    logic [3:0] vals [4];
    vals = '{4'd0, 4'd2, 4'd10, 4'd15};
    foreach (vals[i]) begin
      stretchCycles = vals[i];
      xmv(1'b0, 8'h00);
      chk("stretch", xmvCycles, (vals[i] > 10 ? SFRDP_MAX_STRETCH : vals[i]) + 1);
    end
    stretchCycles = 4'd0;
  endtask : t_stretch

  task automatic t_auto();
    set_ptr(1'b0, 16'h20FF);
    wr(SFRDP_ADDR_PCTL, 8'h60);
    pulse(1'b1);
    chk("toggle", activePtr, 1'b1);
    rdchk("inc lo", SFRDP_ADDR_DPL0, 8'h00);
    rdchk("inc hi", SFRDP_ADDR_DPH0, 8'h21);
    pulse(1'b0);
    chk("no use", activePtr, 1'b1);
    pulse(1'b1);
    chk("back", extAddr, 16'h2100);
    set_ptr(1'b0, 16'h2000);
    wr(SFRDP_ADDR_PCTL, 8'hD0);
    pulse(1'b1);
    chk("dec", extAddr, 16'h1FFF);
    chk("no tgl", activePtr, 1'b0);
    wr(SFRDP_ADDR_PCTL, 8'h91);
    pulse(1'b1);
    chk("dec one", extAddr, 16'hFF04);
    chk("keep sel", activePtr, 1'b1);
    wr(SFRDP_ADDR_PCTL, 8'hFF);
    rdchk("pctl", SFRDP_ADDR_PCTL, SFRDP_PCTL_MASK);
  endtask : t_auto

  task automatic finish_test();
    $display("checks %0d failures %0d", checksDone, nFail);
    if (nFail == 0 && checksDone > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test

  // ==================
  // main sequence and watchdog
  initial begin
    {dirValid, dirIndirect, dirWrite, dirBitOp, xmvValid, xmvWrite} = 6'h00;
    {instrDone, instrUsedPtr} = 2'b00;
    {dirAddr, dirWrData, xmvWrData} = 24'h0;
    dirBitSel     = 3'h0;
    stretchCycles = 4'h0;
    xramEnable    = 1'b1;
    sys_rst       = 1'b1;
    repeat (5) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'b0;
    t_reset();
    t_regs();
    t_access();
    t_ptr();
    t_stretch();
    t_auto();
    finish_test();
  end

  initial begin
    repeat (20000) @(posedge clk);
    nFail++;
    finish_test();
  end
endmodule : sfrdp_sfr_space_test
